/* src/dfi_params.svh */
// constants for the digital input function block: offsets, codes, timing
// assumes inclusion by dfi_pkg users; definitions only
`ifndef DFI_PARAMS_SVH
`define DFI_PARAMS_SVH

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define DFI_CLK_MHZ 40
`define DFI_TICK_US 100
`define DFI_TICK_CYC (`DFI_CLK_MHZ * `DFI_TICK_US)
`define DFI_ACC_STEP 16'h0010
`define DFI_ESTOP_STEP 16'h0080
`define DFI_MAX_FREQ 16'h1770

// -----------------------------------------------------------------
// register byte offsets and reset values
// -----------------------------------------------------------------
`define DFI_A_CTRL 12'h000
`define DFI_A_ASGLO 12'h004
`define DFI_A_ASGHI 12'h008
`define DFI_A_PRESET 12'h00C
`define DFI_A_KEYPAD 12'h010
`define DFI_A_STATUS 12'h014
`define DFI_A_FREQ 12'h018
`define DFI_CTRL_RST 32'h0000_0110
`define DFI_ASG_RST 32'h0000_0000
`define DFI_PRESET_RST 16'h0000

// -----------------------------------------------------------------
// control and keypad field positions
// -----------------------------------------------------------------
`define DFI_CB_RETAIN 0
`define DFI_CB_PID 1
`define DFI_CB_SRCH 2
`define DFI_CB_MRUN 4
`define DFI_CB_ARUN 6
`define DFI_CB_MFREQ 8
`define DFI_CB_AFREQ 10
`define DFI_KB_RUN 0
`define DFI_KB_RST 1

// -----------------------------------------------------------------
// input function codes
// -----------------------------------------------------------------
`define DFI_FN_HOLD 8'h0B
`define DFI_FN_ALTRUN 8'h0C
`define DFI_FN_ALTFRQ 8'h0D
`define DFI_FN_ESTOP 8'h0E
`define DFI_FN_BBLK 8'h0F
`define DFI_FN_FRST 8'h11
`define DFI_FN_SS1 8'h13
`define DFI_FN_EXTF 8'h19
`define DFI_FN_WIRE3 8'h1A
`define DFI_FN_LOCAL 8'h1B
`define DFI_FN_REMCOM 8'h1C
`define DFI_FN_SS2 8'h22

`endif

/* src/dfi_pkg.sv */
// types shared by the digital input function block
// assumes nothing beyond the params header
package dfi_pkg;

  typedef enum logic [6:0] {
    ST_STOP = 7'h01,
    ST_ACCEL = 7'h02,
    ST_RUN = 7'h04,
    ST_DECEL = 7'h08,
    ST_BLOCK = 7'h10,
    ST_ESTOP = 7'h20,
    ST_FAULT = 7'h40
  } dfi_state_t;

  typedef enum logic [1:0] {
    SRC_KEYPAD = 2'h0,
    SRC_TERM = 2'h1,
    SRC_COMM = 2'h2,
    SRC_RSVD = 2'h3
  } dfi_src_t;

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
  } dfi_dec_st_t;

  typedef struct packed {
    dfi_state_t state;
    logic [15:0] outFreq;
    logic outEn;
    logic [15:0] storedRef;
    logic storedValid;
    logic loadNv;
    logic nvWe;
    logic holdPrev;
    logic rstPrev;
    logic warn;
    logic wasDecel;
    logic runLock;
    logic locMode;
    logic [3:0] bbInd;
    logic [3:0] efInd;
    logic faultInd;
    logic ledOn;
    logic threeRun;
    logic [11:0] tickCnt;
    logic tick;
    logic [31:0] ctrl;
    logic [31:0] asgLo;
    logic [31:0] asgHi;
    logic [15:0] preset;
    logic keyRun;
    logic keyRst;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dfi_top_st_t;

endpackage : dfi_pkg

/* src/dfi_fn_if.sv */
// decoded input functions passed from the decoder to the core
// assumes one clock domain; driven by the decoder only
`timescale 1ns/10ps
interface dfi_fn_if;
  logic hold;
  logic altRun;
  logic altFreq;
  logic estop;
  logic bblk;
  logic [3:0] bbNum;
  logic frst;
  logic ss1;
  logic ss2;
  logic extf;
  logic [3:0] efNum;
  logic threeWire;
  logic localSel;
  logic remCom;
  logic runTerm;
  logic stopTerm;
  modport src (output hold, altRun, altFreq, estop, bblk, bbNum, frst,
    ss1, ss2, extf, efNum, threeWire, localSel, remCom, runTerm, stopTerm);
  modport dst (input hold, altRun, altFreq, estop, bblk, bbNum, frst,
    ss1, ss2, extf, efNum, threeWire, localSel, remCom, runTerm, stopTerm);
endinterface : dfi_fn_if

/* src/dfi_input_decode.sv */
// synchroniser and function decoder for the eight input terminals
// assumes terminals are static levels; assignments come from registers
`timescale 1ns/10ps
`include "dfi_params.svh"
module dfi_input_decode
  import dfi_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, low
  input wire logic [7:0] terminals, // raw input levels
  input wire logic [63:0] assign8, // function code per terminal
  dfi_fn_if.src fn // decoded functions
);

  dfi_dec_st_t st;
  dfi_dec_st_t next_st;
  logic wire3;
  logic [7:0] lvl;

  function automatic logic [7:0] fnMask(input logic [63:0] asg,
      input logic [7:0] act, input logic [7:0] code, input logic excl);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = act[i] && (asg[8*i +: 8] == code) && !(excl && i < 2);
    end
    return m;
  endfunction : fnMask

  function automatic logic [3:0] termNum(input logic [7:0] m);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        n = 4'(i + 1);
      end
    end
    return n;
  endfunction : termNum

  // -----------------------------------------------------------------
  // two-flop synchroniser
  // -----------------------------------------------------------------
  always_comb begin
    next_st.sync1 = terminals;
    next_st.sync2 = st.sync1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------
  // decode; in 3-wire mode terminals one and two are run/stop only
  // -----------------------------------------------------------------
  assign lvl = st.sync2;
  assign wire3 = |fnMask(assign8, 8'h3C, `DFI_FN_WIRE3, 1'b0);
  assign fn.threeWire = wire3;
  assign fn.runTerm = lvl[0];
  assign fn.stopTerm = lvl[1];
  assign fn.hold = |fnMask(assign8, lvl, `DFI_FN_HOLD, wire3);
  assign fn.altRun = |fnMask(assign8, lvl, `DFI_FN_ALTRUN, wire3);
  assign fn.altFreq = |fnMask(assign8, lvl, `DFI_FN_ALTFRQ, wire3);
  assign fn.estop = |fnMask(assign8, lvl, `DFI_FN_ESTOP, wire3);
  assign fn.bblk = |fnMask(assign8, lvl, `DFI_FN_BBLK, wire3);
  assign fn.bbNum = termNum(fnMask(assign8, lvl, `DFI_FN_BBLK, wire3));
  assign fn.frst = |fnMask(assign8, lvl, `DFI_FN_FRST, wire3);
  assign fn.ss1 = |fnMask(assign8, lvl, `DFI_FN_SS1, wire3);
  assign fn.ss2 = |fnMask(assign8, lvl, `DFI_FN_SS2, wire3);
  assign fn.extf = |fnMask(assign8, lvl, `DFI_FN_EXTF, wire3);
  assign fn.efNum = termNum(fnMask(assign8, lvl, `DFI_FN_EXTF, wire3));
  assign fn.localSel = |fnMask(assign8, lvl, `DFI_FN_LOCAL, wire3);
  assign fn.remCom = |fnMask(assign8, lvl, `DFI_FN_REMCOM, wire3);

endmodule : dfi_input_decode

/* src/dfi_top.sv */
// digital input function core: sources, hold, stops, faults, apb regs
// assumes apb master in the clk domain and terminals synchronous-free
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "dfi_params.svh"

module dfi_top
  import dfi_pkg::*;
(
  input wire logic clk, // 40 MHz clock
  input wire logic rst_n, // sync reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [7:0] terminals, // input terminals one..eight
  input wire logic [15:0] analogRef, // terminal analog reference
  input wire logic [15:0] commRef, // serial port reference
  input wire logic commRun, // serial port run command
  input wire logic [15:0] pidRef, // pid output reference
  input wire logic driveFault, // internal fault event
  input wire logic [15:0] nvRefIn, // stored reference at power-up
  input wire logic nvValidIn, // stored reference valid
  output logic [15:0] outFreq, // frequency reference to modulator
  output logic outEnable, // output stage enable
  output logic running, // run state indicator
  output logic [3:0] baseblockIndication, // blocking terminal, 0 none
  output logic [3:0] extFaultIndication, // fault terminal, 0 none
  output logic faultIndication, // fault shown
  output logic noStoredRefWarning, // no stored reference
  output logic runSourceLed, // run source indicator
  output logic refSourceLed, // reference source indicator
  output logic nvWrite, // store pulse to nonvolatile memory
  output logic [15:0] nvRefOut // value to store
);

  dfi_fn_if fn ();

  dfi_top_st_t st;
  dfi_top_st_t next_st;
  dfi_src_t runSrc;
  dfi_src_t frqSrc;
  logic runCmd;
  logic [15:0] selRef;
  logic [15:0] target;
  logic [15:0] startFreq;
  logic resetReq;
  logic apbAcc;
  logic apbWr;
  logic mapped;

  function automatic logic [15:0] rampTo(input logic [15:0] cur,
      input logic [15:0] tgt, input logic [15:0] step);
    logic [15:0] r;
    r = tgt;
    if (cur < tgt && (tgt - cur) > step) begin
      r = cur + step;
    end else if (cur > tgt && (cur - tgt) > step) begin
      r = cur - step;
    end
    return r;
  endfunction : rampTo

  function automatic logic isMapped(input logic [11:0] a);
    return a == `DFI_A_CTRL || a == `DFI_A_ASGLO || a == `DFI_A_ASGHI ||
      a == `DFI_A_PRESET || a == `DFI_A_KEYPAD || a == `DFI_A_STATUS ||
      a == `DFI_A_FREQ;
  endfunction : isMapped

  dfi_input_decode u_decode (
    .clk(clk),
    .rst_n(rst_n),
    .terminals(terminals),
    .assign8({st.asgHi, st.asgLo}),
    .fn(fn)
  );

  // -----------------------------------------------------------------
  // source selection
  // -----------------------------------------------------------------
  always_comb begin
    if (st.locMode) begin
      runSrc = SRC_KEYPAD;
      frqSrc = SRC_KEYPAD;
    end else if (fn.remCom) begin
      runSrc = SRC_COMM;
      frqSrc = SRC_COMM;
    end else begin
      runSrc = fn.altRun ? dfi_src_t'(st.ctrl[`DFI_CB_ARUN +: 2]) :
        dfi_src_t'(st.ctrl[`DFI_CB_MRUN +: 2]);
      frqSrc = fn.altFreq ? dfi_src_t'(st.ctrl[`DFI_CB_AFREQ +: 2]) :
        dfi_src_t'(st.ctrl[`DFI_CB_MFREQ +: 2]);
    end
    case (runSrc)
      SRC_KEYPAD: runCmd = st.keyRun;
      SRC_COMM: runCmd = commRun;
      default: runCmd = fn.threeWire ? st.threeRun : fn.runTerm;
    endcase
    case (frqSrc)
      SRC_KEYPAD: selRef = st.preset;
      SRC_COMM: selRef = commRef;
      default: selRef = analogRef;
    endcase
    if (!st.locMode && !fn.remCom && st.ctrl[`DFI_CB_PID]) begin
      selRef = pidRef;
    end
    // hold: stored value when retained and valid, else freeze at present output
    if (fn.hold && st.ctrl[`DFI_CB_RETAIN] && st.storedValid) begin
      target = st.storedRef;
    end else if (fn.hold) begin
      target = st.outFreq;
    end else begin
      target = selRef;
    end
    if (fn.ss1) begin
      startFreq = `DFI_MAX_FREQ;
    end else if (fn.ss2 || st.ctrl[`DFI_CB_SRCH]) begin
      startFreq = target;
    end else begin
      startFreq = 16'h0000;
    end
    resetReq = (fn.frst && !st.rstPrev) || st.keyRst;
  end

  // -----------------------------------------------------------------
  // apb slave, one wait state
  // -----------------------------------------------------------------
  assign apbAcc = psel && penable && st.pready;
  assign apbWr = apbAcc && pwrite;
  assign mapped = isMapped(paddr);

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.nvWe = 1'b0;
    next_st.keyRst = 1'b0;
    next_st.loadNv = 1'b0;
    next_st.holdPrev = fn.hold;
    next_st.rstPrev = fn.frst;

    // ramp tick divider
    next_st.tick = 1'b0;
    if (st.tickCnt == 12'(`DFI_TICK_CYC - 1)) begin
      next_st.tickCnt = 12'h000;
      next_st.tick = 1'b1;
    end else begin
      next_st.tickCnt = st.tickCnt + 12'h001;
    end

    // stored reference returns from nonvolatile memory after reset
    if (st.loadNv) begin
      next_st.storedRef = nvRefIn;
      next_st.storedValid = nvValidIn;
    end

    // 3-wire latch: stop terminal wins over run terminal
    if (fn.stopTerm) begin
      next_st.threeRun = 1'b0;
    end else if (fn.runTerm) begin
      next_st.threeRun = 1'b1;
    end

    // lockout after estop or decel-block holds until run removed
    if (!runCmd) begin
      next_st.runLock = 1'b0;
    end

    // local/remote only follows the input while stopped
    if (st.state == ST_STOP) begin
      next_st.locMode = fn.localSel;
    end
    next_st.ledOn = !next_st.locMode;

    // capture reference on hold onset while retaining
    if (fn.hold && !st.holdPrev && st.ctrl[`DFI_CB_RETAIN] &&
        st.state != ST_STOP) begin
      next_st.storedRef = selRef;
      next_st.storedValid = 1'b1;
      next_st.nvWe = 1'b1;
    end
    if (!fn.hold) begin
      next_st.warn = 1'b0;
    end

    // main sequencer, fault above block above emergency stop
    case (st.state)
      ST_FAULT: begin
        next_st.outEn = 1'b0;
        next_st.outFreq = 16'h0000;
        if (resetReq && !runCmd && !driveFault && !fn.extf) begin
          next_st.state = ST_STOP;
          next_st.faultInd = 1'b0;
          next_st.efInd = 4'h0;
        end
      end
      ST_BLOCK: begin
        next_st.outEn = 1'b0;
        next_st.bbInd = fn.bbNum;
        if (!fn.bblk) begin
          next_st.bbInd = 4'h0;
          if (st.wasDecel || !runCmd) begin
            next_st.state = ST_STOP;
            next_st.outFreq = 16'h0000;
            next_st.runLock = st.wasDecel;
          end else begin
            next_st.state = ST_ACCEL;
            next_st.outEn = 1'b1;
            next_st.outFreq = st.ctrl[`DFI_CB_SRCH] ?
              target : 16'h0000;
          end
        end
      end
      ST_ESTOP: begin
        if (st.tick) begin
          next_st.outFreq = rampTo(st.outFreq, 16'h0000,
            `DFI_ESTOP_STEP);
        end
        if (st.outFreq == 16'h0000) begin
          next_st.state = ST_STOP;
          next_st.outEn = 1'b0;
          next_st.runLock = 1'b1;
        end
      end
      ST_STOP: begin
        next_st.outEn = 1'b0;
        next_st.outFreq = 16'h0000;
        if (runCmd && !st.runLock) begin
          next_st.state = ST_ACCEL;
          next_st.outEn = 1'b1;
          next_st.outFreq = startFreq;
          if (fn.hold && !(st.ctrl[`DFI_CB_RETAIN] && st.storedValid)) begin
            next_st.warn = 1'b1;
          end
        end
      end
      ST_ACCEL, ST_RUN, ST_DECEL: begin
        if (!runCmd) begin
          next_st.state = ST_DECEL;
          if (st.tick) begin
            next_st.outFreq = rampTo(st.outFreq, 16'h0000,
              `DFI_ACC_STEP);
          end
          if (st.outFreq == 16'h0000) begin
            next_st.state = ST_STOP;
            next_st.outEn = 1'b0;
          end
        end else begin
          if (st.tick) begin
            next_st.outFreq = rampTo(st.outFreq, target, `DFI_ACC_STEP);
          end
          if (st.outFreq < target) begin
            next_st.state = ST_ACCEL;
          end else if (st.outFreq > target) begin
            next_st.state = ST_DECEL;
          end else begin
            next_st.state = ST_RUN;
          end
        end
      end
      default: begin
        next_st.state = ST_STOP;
        next_st.outEn = 1'b0;
      end
    endcase

    // overriding events; the clear above loses to a new event
    if (driveFault || fn.extf) begin
      next_st.state = ST_FAULT;
      next_st.outEn = 1'b0;
      next_st.outFreq = 16'h0000;
      next_st.faultInd = 1'b1;
      next_st.bbInd = 4'h0;
      if (fn.extf) begin
        next_st.efInd = fn.efNum;
      end
    end else if (fn.bblk && st.state != ST_FAULT &&
        st.state != ST_BLOCK) begin
      next_st.state = ST_BLOCK;
      next_st.outEn = 1'b0;
      next_st.bbInd = fn.bbNum;
      next_st.wasDecel = st.state inside {ST_DECEL, ST_ESTOP};
    end else if (fn.estop && (st.state == ST_ACCEL ||
        st.state == ST_RUN || st.state == ST_DECEL)) begin
      next_st.state = ST_ESTOP;
    end

    // register access
    next_st.pready = psel && penable && !st.pready;
    next_st.pslverr = psel && penable && !st.pready && !mapped;
    next_st.prdata = 32'h0000_0000;
    if (psel && penable && !st.pready && !pwrite) begin
      case (paddr)
        `DFI_A_CTRL: next_st.prdata = st.ctrl;
        `DFI_A_ASGLO: next_st.prdata = st.asgLo;
        `DFI_A_ASGHI: next_st.prdata = st.asgHi;
        `DFI_A_PRESET: next_st.prdata = {16'h0000, st.preset};
        `DFI_A_KEYPAD: next_st.prdata = {31'h0, st.keyRun};
        `DFI_A_STATUS: next_st.prdata = {9'h000, runCmd, st.storedValid,
          fn.threeWire, st.ledOn, st.locMode, st.warn, st.faultInd,
          st.efInd, st.bbInd, st.outEn, st.state};
        `DFI_A_FREQ: next_st.prdata = {st.storedRef, st.outFreq};
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end
    if (apbWr) begin
      case (paddr)
        `DFI_A_CTRL: next_st.ctrl = {20'h00000, pwdata[11:0]};
        `DFI_A_ASGLO: next_st.asgLo = pwdata;
        `DFI_A_ASGHI: next_st.asgHi = pwdata;
        `DFI_A_PRESET: next_st.preset = pwdata[15:0];
        `DFI_A_KEYPAD: begin
          next_st.keyRun = pwdata[`DFI_KB_RUN];
          next_st.keyRst = pwdata[`DFI_KB_RST];
        end
        default: next_st.keyRst = 1'b0;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.state <= ST_STOP;
      st.loadNv <= 1'b1;
      st.ledOn <= 1'b1;
      st.ctrl <= `DFI_CTRL_RST;
      st.asgLo <= `DFI_ASG_RST;
      st.asgHi <= `DFI_ASG_RST;
      st.preset <= `DFI_PRESET_RST;
    end else begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all straight from the state register
  // -----------------------------------------------------------------
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign outFreq = st.outFreq;
  assign outEnable = st.outEn;
  assign running = st.outEn;
  assign baseblockIndication = st.bbInd;
  assign extFaultIndication = st.efInd;
  assign faultIndication = st.faultInd;
  assign noStoredRefWarning = st.warn;
  assign runSourceLed = st.ledOn;
  assign refSourceLed = st.ledOn;
  assign nvWrite = st.nvWe;
  assign nvRefOut = st.storedRef;

endmodule : dfi_top

/* bench/dfi_term_model.sv */
// field wiring model: input terminals and serial run line
// assumes requests from the bench in the clk domain
`timescale 1ns/10ps
module dfi_term_model (
  input wire logic clk, // system clock
  input wire logic [7:0] want, // requested terminal levels
  input wire logic wantRun, // requested serial run
  output logic [7:0] terminals, // terminal levels
  output logic commRun // serial run level
);
  // contacts settle one edge after the request, never mid-cycle
  initial terminals = 8'h00;
  initial commRun = 1'b0;
  always @(posedge clk) begin
    terminals <= want;
    commRun <= wantRun;
  end
endmodule : dfi_term_model

/* bench/dfi_properties.sv */
// assertions on the ports of the digital input function core
// assumes a bind to dfi_top; one clock, sync active-low reset
`timescale 1ns/10ps
module dfi_properties (
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic outEnable, // output stage enable
  input wire logic running, // run indicator
  input wire logic [3:0] baseblockIndication, // blocking terminal
  input wire logic [3:0] extFaultIndication, // fault terminal
  input wire logic faultIndication, // fault shown
  input wire logic runSourceLed, // run source led
  input wire logic refSourceLed // reference source led
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence apbAccess;
    psel && penable;
  endsequence
  one_wait_a: assert property (apbSetup ##1 apbAccess |->
    !pready ##1 pready) else $error("apb answer not after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  data_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  error_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("slave error without answer");
  run_mirror_a: assert property (running == outEnable)
    else $error("running differs from output enable");
  led_pair_a: assert property (runSourceLed == refSourceLed)
    else $error("source indicators disagree");
  fault_off_a: assert property (faultIndication |-> !outEnable)
    else $error("output enabled while fault shown");
  block_off_a: assert property (
    baseblockIndication != 4'h0 |-> !outEnable && baseblockIndication <= 4'h8)
    else $error("output enabled or bad terminal in base block");
  ext_off_a: assert property (extFaultIndication != 4'h0 |-> !outEnable)
    else $error("output enabled during external fault");
  reset_idle_a: assert property (disable iff (1'b0)
    !rst_n |=> !outEnable && runSourceLed && !faultIndication)
    else $error("outputs not idle after reset");
endmodule : dfi_properties

/* bench/drive_digital_input_functions_tb.sv */
// self-checking bench for the digital input function core
// assumes the apb map and input codes of the params header
`timescale 1ns/10ps
`include "dfi_params.svh"
module drive_digital_input_functions_tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, wantRun;
  logic commRun, outEnable, running, faultIndication, noStoredRefWarning;
  logic runSourceLed, refSourceLed, nvWrite;
  logic [7:0] want, terminals;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] outFreq, analogRef, nvRefOut;
  logic [3:0] baseblockIndication, extFaultIndication;
  int fails, num_checks, nvPulses;
  // ----------
  // register rows: address, write value, read back, error
  // ----------
  localparam int NR = 7;
  logic [11:0] ra [NR] = '{`DFI_A_CTRL, `DFI_A_PRESET, `DFI_A_KEYPAD,
    12'h01C, `DFI_A_ASGLO, `DFI_A_ASGHI, `DFI_A_CTRL};
  logic [31:0] rw [NR] = '{32'hFFFF_FFFF, 32'h0001_ABCD, 32'h0000_0002,
    32'hFFFF_FFFF, 32'h190F_0E00, 32'h0B1C_1B11, 32'h0000_0110};
  logic [31:0] rx [NR] = '{32'h0000_0FFF, 32'h0000_ABCD, 32'h0000_0000,
    32'h0000_0000, 32'h190F_0E00, 32'h0B1C_1B11, 32'h0000_0110};
  logic [NR-1:0] re = 7'h08;
  dfi_term_model u_dfi_term_model (.clk(clk), .want(want),
    .wantRun(wantRun), .terminals(terminals), .commRun(commRun));
  dfi_top u_dfi_top (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .terminals(terminals), .analogRef(analogRef), .commRef(16'h0040),
    .commRun(commRun), .pidRef(16'h0050), .driveFault(1'b0),
    .nvRefIn(16'h0000), .nvValidIn(1'b0), .outFreq(outFreq),
    .outEnable(outEnable), .running(running),
    .baseblockIndication(baseblockIndication),
    .extFaultIndication(extFaultIndication),
    .faultIndication(faultIndication),
    .noStoredRefWarning(noStoredRefWarning),
    .runSourceLed(runSourceLed), .refSourceLed(refSourceLed),
    .nvWrite(nvWrite), .nvRefOut(nvRefOut));
  always @(posedge clk) begin
    if (nvWrite === 1'b1) begin
      nvPulses++;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic step(input logic [7:0] t, input int cyc);
    want <= t;
    repeat (cyc) @(posedge clk);
  endtask : step
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard: the whole sequence needs about 53k cycles
  initial begin
    #2000000;
    fails++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, wantRun} = 4'h0;
    {paddr, pwdata, want} = '0;
    analogRef = 16'h0030;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("idle outputs", {runSourceLed, refSourceLed, outEnable}, 3'h6);
    apb(1'b0, `DFI_A_CTRL, 32'h0);
    chk("ctrl reset", rd, `DFI_CTRL_RST);
    for (int i = 0; i < NR; i++) begin
      apb(1'b1, ra[i], rw[i]);
      apb(1'b0, ra[i], 32'h0);
      chk("read back", rd, rx[i]);
      chk("slave error", err, re[i]);
    end
    apb(1'b1, `DFI_A_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, `DFI_A_STATUS, 32'h0);
    chk("status stopped", rd, 32'h0008_0001);
    step(8'h01, 16100);
    chk("ramp target", outFreq, 16'h0030);
    step(8'h05, 6);
    chk("base block", {baseblockIndication, outEnable}, 5'h06);
    step(8'h01, 6);
    chk("block release", {outEnable, outFreq <= 16'h0010}, 2'h3);
    step(8'h09, 6);
    chk("ext fault", {extFaultIndication, faultIndication, outEnable},
      6'h12);
    step(8'h11, 6);
    chk("reset with run", faultIndication, 1'b1);
    step(8'h00, 6);
    step(8'h10, 6);
    chk("fault reset", {faultIndication, outEnable}, 2'h0);
    step(8'h20, 6);
    chk("local mode", runSourceLed, 1'b0);
    step(8'h00, 6);
    step(8'h01, 6);
    step(8'h21, 6);
    chk("local while run", runSourceLed, 1'b1);
    step(8'h00, 4100);
    step(8'h80, 6);
    step(8'h81, 6);
    chk("hold first", {noStoredRefWarning, running}, 2'h3);
    step(8'h00, 4100);
    wantRun <= 1'b1;
    step(8'h00, 6);
    chk("terminal source", running, 1'b0);
    step(8'h40, 6);
    chk("comm source", running, 1'b1);
    wantRun <= 1'b0;
    step(8'h01, 6);
    step(8'h03, 4100);
    chk("estop lock", running, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("power-up run", running, 1'b1);
    step(8'h00, 4100);
    apb(1'b1, `DFI_A_ASGLO, 32'h130D_0F00);
    apb(1'b1, `DFI_A_ASGHI, 32'h0B00_0000);
    apb(1'b1, `DFI_A_CTRL, 32'h0000_0916);
    step(8'h09, 6);
    chk("search max", outFreq, `DFI_MAX_FREQ);
    step(8'h0B, 6);
    step(8'h09, 6);
    chk("decel block", running, 1'b0);
    step(8'h00, 6);
    step(8'h05, 6);
    chk("pid over alt", outFreq, 16'h0050);
    apb(1'b1, `DFI_A_CTRL, 32'h0000_0915);
    step(8'h05, 4100);
    chk("alt frequency", outFreq, 16'h0040);
    step(8'h85, 6);
    chk("stored ref", nvRefOut, 16'h0040);
    chk("store pulse", nvPulses, 32'h1);
    step(8'h80, 16100);
    step(8'h81, 6);
    chk("stored start", {noStoredRefWarning, outFreq}, 17'h00040);
    test_done();
  end
endmodule : drive_digital_input_functions_tb
bind dfi_top dfi_properties u_dfi_properties (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .outEnable(outEnable), .running(running),
  .baseblockIndication(baseblockIndication),
  .extFaultIndication(extFaultIndication),
  .faultIndication(faultIndication), .runSourceLed(runSourceLed),
  .refSourceLed(refSourceLed));
